/* File: rtl/ctp_defines.svh */
// Register offsets, field positions and reset values of the trim/tracking bank
`ifndef CTP_DEFINES_SVH
`define CTP_DEFINES_SVH
`define CTP_OFF_POS_TRIM 8'h22
`define CTP_OFF_NEG_TRIM 8'h23
`define CTP_OFF_PHASE_DET 8'h24
`define CTP_OFF_DUTY 8'h25
`define CTP_OFF_CONTROL 8'h26
`define CTP_OFF_SEARCH 8'h27
`define CTP_OFF_DELAY_HI 8'h28
`define CTP_OFF_GUARD 8'h29
`define CTP_OFF_LOCK_STAT 8'h2A
`define CTP_OFF_IRQ_STAT 8'h2B
`define CTP_OFF_IRQ_MASK 8'h2C
`define CTP_BIT_TRIM_DIR 4
`define CTP_BIT_PD_AUTO 5
`define CTP_BIT_CMP_BOOST 4
`define CTP_BIT_DUTY_AUTO 7
`define CTP_BIT_DUTY_POL 6
`define CTP_BIT_DELAY_LSB 7
`define CTP_BIT_LOCKED 0
`define CTP_BIT_LOST 1
`define CTP_RST_POS_TRIM 8'h00
`define CTP_RST_NEG_TRIM 8'h00
`define CTP_RST_PHASE_DET 8'h00
`define CTP_RST_DUTY 8'h00
`define CTP_RST_CONTROL 8'h42
`define CTP_RST_SEARCH 8'h40
`define CTP_RST_DELAY_HI 8'h00
`define CTP_RST_GUARD 8'h00
`define CTP_RST_IRQ_MASK 2'h0
`endif

/* File: rtl/ctp_pkg.sv */
// Types of the trim/tracking register bank
package ctp_pkg;
  typedef enum logic [2:0] {
    CTP_IDLE = 3'b001,
    CTP_SETUP = 3'b010,
    CTP_ACCESS = 3'b100
  } ctp_phase_type;
endpackage : ctp_pkg

/* File: rtl/ctp_event_latch.sv */
// Sticky event bits with write-one-to-clear and masked interrupt
`timescale 1ns/1ps
module ctp_event_latch #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Events and software clear
  input wire logic [WIDTH-1:0] event_pulse,
  input wire logic [WIDTH-1:0] clear_bits,
  input wire logic [WIDTH-1:0] mask_bits,
  // Status
  output logic [WIDTH-1:0] sticky_q,
  output logic irq
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sticky_q <= '0;
    end else begin
      // Set wins over clear
      sticky_q <= (sticky_q & ~clear_bits) | event_pulse;
    end
  end

  assign irq = |(sticky_q & mask_bits);
endmodule : ctp_event_latch

/* File: rtl/ctp_regs.sv */
// APB register bank for clock trim and phase-tracking control
// Operation
// [RL1] A 4-bit positive-leg trim offset is writable and resets to zero.
// [RL2] The positive-leg direction bit lowers the level at 0 and raises it at 1, reset 0.
// [RL3] A separate 4-bit negative-leg trim offset is writable and resets to zero.
// [RL4] The negative-leg direction bit lowers the level at 0 and raises it at 1, reset 0.
// [RL5] The phase detector auto-correction enable is read/write and resets to zero.
// [RL6] Comparator boost acts only while phase detector auto-correction is on.
// [RL7] The manual boost bias applies only while comparator boost is off.
// [RL8] The duty-cycle auto-correction enable is read/write and resets to zero.
// [RL9] The manual duty adjust applies only while duty auto-correction is off.
// [RL10] The lock status register is read-only: bit 0 locked, bit 1 lock lost.
// [RL11] The 9-bit delay takes its LSB from bit 7 of one register, the rest from the next.
`timescale 1ns/1ps
`include "ctp_defines.svh"
module ctp_regs (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Tracking controller status
  input wire logic tracker_locked,
  input wire logic tracker_lock_lost,
  // Clock leg trim
  output logic [3:0] pos_leg_trim,
  output logic pos_leg_raise,
  output logic [3:0] neg_leg_trim,
  output logic neg_leg_raise,
  // Phase detector
  output logic phase_det_auto_corr_en,
  output logic comparator_boost_en,
  output logic manual_bias_en,
  output logic [3:0] manual_bias,
  // Duty cycle
  output logic tracker_duty_auto_en,
  output logic duty_adjust_polarity,
  output logic manual_duty_en,
  output logic [5:0] duty_manual_adjust,
  // Tracker configuration
  output logic [7:0] tracker_control,
  output logic [4:0] target_phase,
  output logic [1:0] search_direction,
  output logic [8:0] tracker_delay_value,
  output logic [7:0] tracker_guard_retry,
  // Interrupt
  output logic irq
);
  logic [7:0] pos_trim_q;
  logic [7:0] neg_trim_q;
  logic [7:0] phase_det_q;
  logic [7:0] duty_q;
  logic [7:0] control_q;
  logic [7:0] search_q;
  logic [7:0] delay_hi_q;
  logic [7:0] guard_q;
  logic [1:0] irq_mask_q;
  logic [1:0] sticky;
  logic [1:0] locked_prev_q;
  logic [1:0] event_pulse;
  logic [1:0] clear_bits;
  logic [7:0] read_byte;
  logic wr_en;
  logic rd_setup;
  logic wr_low;
  logic access_ok;
  logic addr_hit;
  logic stb_pos_trim;
  logic stb_neg_trim;
  logic stb_phase_det;
  logic stb_duty;
  logic stb_control;
  logic stb_search;
  logic stb_delay_hi;
  logic stb_guard;
  logic stb_irq_stat;
  logic stb_irq_mask;
  ctp_pkg::ctp_phase_type phase_q;
  ctp_pkg::ctp_phase_type phase_d;

  function automatic logic sel(input logic [31:0] addr, input logic [7:0] off);
    sel = (addr[31:10] == 22'h0) && (addr[9:2] == off) && (addr[1:0] == 2'b00);
  endfunction : sel

  // Zero wait states: every access phase completes at once
  assign pready = 1'b1;
  // Only an access phase that follows its setup cycle may write
  assign access_ok = psel && penable && (phase_q == ctp_pkg::CTP_SETUP);
  assign wr_en = access_ok && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  // Low byte write only when its lane is enabled
  assign wr_low = wr_en && pstrb[0];

  // Write strobes, decoded once per register
  assign stb_pos_trim = wr_low && sel(paddr, `CTP_OFF_POS_TRIM);
  assign stb_neg_trim = wr_low && sel(paddr, `CTP_OFF_NEG_TRIM);
  assign stb_phase_det = wr_low && sel(paddr, `CTP_OFF_PHASE_DET);
  assign stb_duty = wr_low && sel(paddr, `CTP_OFF_DUTY);
  assign stb_control = wr_low && sel(paddr, `CTP_OFF_CONTROL);
  assign stb_search = wr_low && sel(paddr, `CTP_OFF_SEARCH);
  assign stb_delay_hi = wr_low && sel(paddr, `CTP_OFF_DELAY_HI);
  assign stb_guard = wr_low && sel(paddr, `CTP_OFF_GUARD);
  assign stb_irq_stat = wr_low && sel(paddr, `CTP_OFF_IRQ_STAT);
  assign stb_irq_mask = wr_low && sel(paddr, `CTP_OFF_IRQ_MASK);

  // Bus phase of the previous cycle; a held access cannot write twice
  always_comb begin
    phase_d = ctp_pkg::CTP_IDLE;
    case (phase_q)
      ctp_pkg::CTP_IDLE: begin
        if (psel && !penable) begin
          phase_d = ctp_pkg::CTP_SETUP;
        end
      end
      ctp_pkg::CTP_SETUP: begin
        if (psel && penable) begin
          phase_d = ctp_pkg::CTP_ACCESS;
        end else if (psel) begin
          phase_d = ctp_pkg::CTP_SETUP;
        end
      end
      ctp_pkg::CTP_ACCESS: begin
        if (psel && !penable) begin
          phase_d = ctp_pkg::CTP_SETUP;
        end
      end
      default: phase_d = ctp_pkg::CTP_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= ctp_pkg::CTP_IDLE;
    end else begin
      phase_q <= phase_d;
    end
  end

  always_comb begin
    addr_hit = 1'b1;
    case (paddr[9:2])
      `CTP_OFF_POS_TRIM: read_byte = pos_trim_q;
      `CTP_OFF_NEG_TRIM: read_byte = neg_trim_q;
      `CTP_OFF_PHASE_DET: read_byte = phase_det_q;
      `CTP_OFF_DUTY: read_byte = duty_q;
      `CTP_OFF_CONTROL: read_byte = control_q;
      `CTP_OFF_SEARCH: read_byte = search_q;
      `CTP_OFF_DELAY_HI: read_byte = delay_hi_q;
      `CTP_OFF_GUARD: read_byte = guard_q;
      `CTP_OFF_LOCK_STAT: read_byte = {6'h00, tracker_lock_lost, tracker_locked}; // [RL10]
      `CTP_OFF_IRQ_STAT: read_byte = {6'h00, sticky};
      `CTP_OFF_IRQ_MASK: read_byte = {6'h00, irq_mask_q};
      default: begin
        read_byte = 8'h00;
        addr_hit = 1'b0;
      end
    endcase
    if ((paddr[31:10] != 22'h0) || (paddr[1:0] != 2'b00)) begin
      addr_hit = 1'b0;
    end
  end

  // Unmapped access answers with error; writes there are dropped
  assign pslverr = psel && penable && !addr_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= {24'h00_0000, read_byte};
    end
  end

  // Trim bits 7:5 are unused and read as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_trim_q <= `CTP_RST_POS_TRIM;
    end else if (stb_pos_trim) begin
      pos_trim_q <= {3'b000, pwdata[4:0]}; // [RL1] [RL2]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      neg_trim_q <= `CTP_RST_NEG_TRIM;
    end else if (stb_neg_trim) begin
      neg_trim_q <= {3'b000, pwdata[4:0]}; // [RL3] [RL4]
    end
  end

  // Phase detector bits 7:6 are unused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_det_q <= `CTP_RST_PHASE_DET;
    end else if (stb_phase_det) begin
      phase_det_q <= {2'b00, pwdata[5:0]}; // [RL5]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_q <= `CTP_RST_DUTY;
    end else if (stb_duty) begin
      duty_q <= pwdata[7:0]; // [RL8]
    end
  end

  // Control bit 7 is unused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_q <= `CTP_RST_CONTROL;
    end else if (stb_control) begin
      control_q <= {1'b0, pwdata[6:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      search_q <= `CTP_RST_SEARCH;
    end else if (stb_search) begin
      search_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delay_hi_q <= `CTP_RST_DELAY_HI;
    end else if (stb_delay_hi) begin
      delay_hi_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      guard_q <= `CTP_RST_GUARD;
    end else if (stb_guard) begin
      guard_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= `CTP_RST_IRQ_MASK;
    end else if (stb_irq_mask) begin
      irq_mask_q <= pwdata[1:0];
    end
  end

  // Rising edges of locked and lost raise events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      locked_prev_q <= 2'b00;
    end else begin
      locked_prev_q <= {tracker_lock_lost, tracker_locked};
    end
  end

  assign event_pulse = {tracker_lock_lost, tracker_locked} & ~locked_prev_q;
  assign clear_bits = stb_irq_stat ? pwdata[1:0] : 2'b00;

  ctp_event_latch #(
    .WIDTH(2)
  ) u_events (
    .pclk(pclk),
    .presetn(presetn),
    .event_pulse(event_pulse),
    .clear_bits(clear_bits),
    .mask_bits(irq_mask_q),
    .sticky_q(sticky),
    .irq(irq)
  );

  assign pos_leg_trim = pos_trim_q[3:0]; // [RL1]
  assign pos_leg_raise = pos_trim_q[`CTP_BIT_TRIM_DIR]; // [RL2]
  assign neg_leg_trim = neg_trim_q[3:0]; // [RL3]
  assign neg_leg_raise = neg_trim_q[`CTP_BIT_TRIM_DIR]; // [RL4]
  assign phase_det_auto_corr_en = phase_det_q[`CTP_BIT_PD_AUTO]; // [RL5]
  assign comparator_boost_en = phase_det_q[`CTP_BIT_PD_AUTO] &&
                               phase_det_q[`CTP_BIT_CMP_BOOST]; // [RL6]
  // Ignored fields show zero on the output; the register keeps them
  assign manual_bias_en = !comparator_boost_en; // [RL7]
  assign manual_bias = manual_bias_en ? phase_det_q[3:0] : 4'h0; // [RL7]
  assign tracker_duty_auto_en = duty_q[`CTP_BIT_DUTY_AUTO]; // [RL8]
  assign duty_adjust_polarity = duty_q[`CTP_BIT_DUTY_POL];
  assign manual_duty_en = !duty_q[`CTP_BIT_DUTY_AUTO]; // [RL9]
  assign duty_manual_adjust = manual_duty_en ? duty_q[5:0] : 6'h00; // [RL9]
  assign tracker_control = control_q;
  assign target_phase = search_q[4:0];
  assign search_direction = search_q[6:5];
  assign tracker_delay_value = {delay_hi_q, search_q[`CTP_BIT_DELAY_LSB]}; // [RL11]
  assign tracker_guard_retry = guard_q;
endmodule : ctp_regs

/* File: verification/ctp_regs_checker.sv */
// Assertion checker of the trim/tracking register bank
`timescale 1ns/1ps
module ctp_regs_checker (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // Register outputs
  input wire logic [3:0] pos_leg_trim,
  input wire logic pos_leg_raise,
  input wire logic phase_det_auto_corr_en,
  input wire logic comparator_boost_en,
  input wire logic manual_bias_en,
  input wire logic [3:0] manual_bias,
  input wire logic tracker_duty_auto_en,
  input wire logic [5:0] duty_manual_adjust,
  input wire logic [8:0] tracker_delay_value
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wr = psel && penable && pwrite && pstrb[0];
  pos_trim_a: assert property (wr && paddr == 32'h88 |=> pos_leg_trim == $past(pwdata[3:0]))
    else $error("trim not written");
  pos_dir_a: assert property (wr && paddr == 32'h88 |=> pos_leg_raise == $past(pwdata[4]))
    else $error("direction not written");
  pd_auto_a: assert property (wr && paddr == 32'h90 |=> phase_det_auto_corr_en == $past(pwdata[5]))
    else $error("auto enable not written");
  boost_gate_a: assert property (comparator_boost_en |-> phase_det_auto_corr_en)
    else $error("boost without auto");
  bias_gate_a: assert property (comparator_boost_en |-> !manual_bias_en && manual_bias == 4'h0)
    else $error("bias not ignored");
  duty_auto_a: assert property (wr && paddr == 32'h94 |=> tracker_duty_auto_en == $past(pwdata[7]))
    else $error("duty auto not written");
  duty_gate_a: assert property (tracker_duty_auto_en |-> duty_manual_adjust == 6'h00)
    else $error("duty adjust not ignored");
  delay_hi_a: assert property (wr && paddr == 32'hA0 |=> tracker_delay_value[8:1] == $past(pwdata[7:0]))
    else $error("delay upper bits wrong");
endmodule : ctp_regs_checker

bind ctp_regs ctp_regs_checker chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .pos_leg_trim, .pos_leg_raise, .phase_det_auto_corr_en, .comparator_boost_en,
  .manual_bias_en, .manual_bias, .tracker_duty_auto_en, .duty_manual_adjust, .tracker_delay_value);

/* File: verification/testbench.sv */
// Self-checking bench of the trim/tracking register bank
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
$display("wrong value at %0t got %h exp %h", $time, a, e); end end
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rerr;
  logic [31:0] paddr, pwdata, prdata, rdat;
  logic [3:0] pstrb = 4'hF;
  logic tracker_locked, tracker_lock_lost, pos_leg_raise, neg_leg_raise;
  logic phase_det_auto_corr_en, comparator_boost_en, manual_bias_en;
  logic tracker_duty_auto_en, duty_adjust_polarity, manual_duty_en;
  logic [3:0] pos_leg_trim, neg_leg_trim, manual_bias;
  logic [5:0] duty_manual_adjust;
  logic [7:0] tracker_control, tracker_guard_retry;
  logic [4:0] target_phase;
  logic [1:0] search_direction;
  logic [8:0] tracker_delay_value;
  int miscompares = 0;
  int cmp_count = 0;
  ctp_regs uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tracker_locked(tracker_locked), .tracker_lock_lost(tracker_lock_lost),
    .pos_leg_trim(pos_leg_trim), .pos_leg_raise(pos_leg_raise), .neg_leg_trim(neg_leg_trim),
    .neg_leg_raise(neg_leg_raise), .phase_det_auto_corr_en(phase_det_auto_corr_en),
    .comparator_boost_en(comparator_boost_en), .manual_bias_en(manual_bias_en),
    .manual_bias(manual_bias), .tracker_duty_auto_en(tracker_duty_auto_en),
    .duty_adjust_polarity(duty_adjust_polarity), .manual_duty_en(manual_duty_en),
    .duty_manual_adjust(duty_manual_adjust), .tracker_control(tracker_control),
    .target_phase(target_phase), .search_direction(search_direction),
    .tracker_delay_value(tracker_delay_value), .tracker_guard_retry(tracker_guard_retry),
    .irq(irq)
  );
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Request stands until pready is seen high at a rising edge
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Outputs are compared once the write has settled
    @(negedge pclk);
  endtask : xfer
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    `CHK(rdat, e)
  endtask : rd
  task finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    #200us;
    miscompares++;
    finish_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, tracker_locked, tracker_lock_lost} = 6'h00;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd(32'h88 + 32'(4 * i), i == 4 ? 32'h42 : i == 5 ? 32'h40 : 32'h0);
    end
    `CHK({tracker_control, search_direction, target_phase, tracker_guard_retry}, 23'h214000)
    wr(32'h88, 32'hFF);
    wr(32'h8C, 32'hFF);
    rd(32'h88, 32'h1F);
    `CHK({pos_leg_raise, pos_leg_trim, neg_leg_raise, neg_leg_trim}, 10'h3FF)
    wr(32'h88, 32'h03);
    wr(32'h8C, 32'h1A);
    rd(32'h8C, 32'h1A);
    `CHK({pos_leg_raise, pos_leg_trim, neg_leg_raise, neg_leg_trim}, 10'h07A)
    wr(32'h90, 32'h3F);
    rd(32'h90, 32'h3F);
    `CHK({phase_det_auto_corr_en, comparator_boost_en, manual_bias_en, manual_bias}, 7'h60)
    wr(32'h90, 32'h1A);
    `CHK({phase_det_auto_corr_en, comparator_boost_en, manual_bias_en, manual_bias}, 7'h1A)
    wr(32'h94, 32'hC5);
    rd(32'h94, 32'hC5);
    `CHK({tracker_duty_auto_en, duty_adjust_polarity, manual_duty_en, duty_manual_adjust}, 9'h180)
    wr(32'h94, 32'h45);
    `CHK({tracker_duty_auto_en, duty_adjust_polarity, manual_duty_en, duty_manual_adjust}, 9'h0C5)
    wr(32'h9C, 32'h80);
    wr(32'hA0, 32'hB3);
    `CHK(tracker_delay_value, 9'h167)
    wr(32'h98, 32'hFF);
    wr(32'hA4, 32'h5C);
    wr(32'h9C, 32'h55);
    `CHK({tracker_control, search_direction, target_phase, tracker_guard_retry}, 23'h3FD55C)
    `CHK(tracker_delay_value, 9'h166)
    @(posedge pclk);
    tracker_locked <= 1'b1;
    tracker_lock_lost <= 1'b1;
    rd(32'hA8, 32'h3);
    wr(32'hA8, 32'h0);
    rd(32'hA8, 32'h3);
    `CHK(irq, 1'b0)
    wr(32'hB0, 32'h3);
    `CHK(irq, 1'b1)
    rd(32'hAC, 32'h3);
    wr(32'hAC, 32'h1);
    rd(32'hAC, 32'h2);
    wr(32'hB0, 32'h1);
    `CHK(irq, 1'b0)
    rd(32'h100, 32'h0);
    `CHK(rerr, 1'b1)
    finish_test();
  end
endmodule : testbench
